// ---- acc_pkg.sv ----
// constants shared by the converter control block and its sar engine
// assumes a 20 MHz system clock and a 32-bit register bus with byte addresses
package acc_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int RES_W = 8;
	localparam int CH_W = 2;
	localparam int EVT_W = 3;

	// ************************************************************
	// register indices, byte address is four times the index
	// ************************************************************
	localparam logic [9:0] IDX_P0_PINS = 10'h080;
	localparam logic [9:0] IDX_GIE = 10'h0A8;
	localparam logic [9:0] IDX_CTRL = 10'h0C0;
	localparam logic [9:0] IDX_RESULT = 10'h0C5;
	localparam logic [9:0] IDX_IEN1 = 10'h0E8;
	localparam logic [9:0] IDX_P0_DIS = 10'h0F6;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h100;
	localparam logic [9:0] IDX_IRQ_ENA = 10'h101;
	localparam logic [9:0] IDX_IRQ_CLR = 10'h102;
	localparam logic [9:0] IDX_CONV_STAT = 10'h103;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTL_ENABLE = 7;
	localparam int CTL_RESULT_REGISTER_OUT = 5;
	localparam int CTL_DONE = 4;
	localparam int CTL_START = 3;
	localparam int CTL_CH_LO = 0;
	localparam int GIE_BIT = 7;
	localparam int IEN1_CONV_IE = 4;
	localparam int EVT_DONE = 0;
	localparam int EVT_START_REFUSED = 1;
	localparam int EVT_ENA_REFUSED = 2;
	localparam int CST_SETTLED = 0;
	localparam int CST_BUSY = 1;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [7:0] P0_DIS_RST = 8'h00;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_NS = 50;
	localparam int SETTLE_NS = 10000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAR_BIT_CYC = 8;

	typedef enum logic [1:0]
	{
		ACC_SAR_IDLE = 2'b00,
		ACC_SAR_SETTLE = 2'b01,
		ACC_SAR_DECIDE = 2'b10
	} acc_sar_state_t;

endpackage

// ---- acc_sar_engine.sv ----
// successive approximation sequencer: drives a trial code to the analog dac
// assumes cmp_pin is high while the input voltage is at or above the trial level
`timescale 1ns/100ps
module acc_sar_engine
#(
	parameter int BIT_CYC = acc_pkg::SAR_BIT_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic start,
	input wire logic cmp_pin,
	output logic [acc_pkg::RES_W-1:0] trial,
	output logic [acc_pkg::RES_W-1:0] result,
	output logic done
);
	localparam int IDX_W = $clog2(acc_pkg::RES_W);
	localparam int WAIT_W = $clog2(BIT_CYC + 1);
	localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(BIT_CYC - 1);

	typedef struct packed
	{
		acc_pkg::acc_sar_state_t state;
		logic [IDX_W-1:0] bit_idx;
		logic [WAIT_W-1:0] wait_cnt;
		logic [acc_pkg::RES_W-1:0] trial;
		logic [acc_pkg::RES_W-1:0] result;
		logic done;
		logic [2:0] sync;
		logic cmp;
	} acc_sar_t;

	acc_sar_t q;
	acc_sar_t n;

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb
	begin
		logic [acc_pkg::RES_W-1:0] tr;
		tr = q.trial;
		n = q;
		n.done = 1'b0;
		// the comparator is asynchronous: three stages, a change counts once two agree
		n.sync = {q.sync[1:0], cmp_pin};
		if (q.sync[1] == q.sync[2])
			n.cmp = q.sync[2];
		case (q.state)
			acc_pkg::ACC_SAR_IDLE:
			begin
				if (start)
				begin
					n.trial = {1'b1, {(acc_pkg::RES_W-1){1'b0}}};
					n.bit_idx = IDX_W'(acc_pkg::RES_W - 1);
					n.wait_cnt = WAIT_LOAD;
					n.state = acc_pkg::ACC_SAR_SETTLE;
				end
			end
			acc_pkg::ACC_SAR_SETTLE:
			begin
				// bit time must cover the synchroniser latency
				if (q.wait_cnt == '0)
					n.state = acc_pkg::ACC_SAR_DECIDE;
				else
					n.wait_cnt = q.wait_cnt - WAIT_W'(1);
			end
			acc_pkg::ACC_SAR_DECIDE:
			begin
				// half-lsb offset in the analog dac gives round-to-nearest codes
				if (!q.cmp)
					tr[q.bit_idx] = 1'b0;
				if (q.bit_idx == '0)
				begin
					n.result = tr;
					n.done = 1'b1;
					n.state = acc_pkg::ACC_SAR_IDLE;
				end
				else
				begin
					tr[q.bit_idx - IDX_W'(1)] = 1'b1;
					n.bit_idx = q.bit_idx - IDX_W'(1);
					n.wait_cnt = WAIT_LOAD;
					n.state = acc_pkg::ACC_SAR_SETTLE;
				end
				n.trial = tr;
			end
			default:
			begin
				n.state = acc_pkg::ACC_SAR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q <= '0;
		else if (ce)
			q <= n;
	end

	assign trial = q.trial;
	assign result = q.result;
	assign done = q.done;

endmodule

// ---- acc_conv_ctrl.sv ----
// converter control: registers, start/busy/done flags, channel lock, port 0 input gating
// assumes an avalon-mm master on the system clock and an external analog mux, dac and comparator
`timescale 1ns/100ps
module acc_conv_ctrl
#(
	parameter int SETTLE_CYC = acc_pkg::SETTLE_CYC,
	parameter int BIT_CYC = acc_pkg::SAR_BIT_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [acc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [acc_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [acc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic [acc_pkg::CH_W-1:0] mux_channel,
	output logic [acc_pkg::RES_W-1:0] sar_trial,
	input wire logic cmp_pin,
	output logic result_register_drive,
	output logic [acc_pkg::RES_W-1:0] result_register_level,
	input wire logic [7:0] port0_pin,
	output logic [7:0] port0_input_off
);
	localparam int SCNT_W = $clog2(SETTLE_CYC + 1);
	localparam logic [SCNT_W-1:0] SCNT_FULL = SCNT_W'(SETTLE_CYC);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed
	{
		logic ack;
		logic [acc_pkg::DATA_W-1:0] rdata;
		logic enable;
		logic result_register_out;
		logic done;
		logic start;
		logic [acc_pkg::CH_W-1:0] channel;
		logic [acc_pkg::RES_W-1:0] result;
		logic [7:0] p0_dis;
		logic gie;
		logic conv_ie;
		logic [acc_pkg::EVT_W-1:0] evt_stat;
		logic [acc_pkg::EVT_W-1:0] evt_ena;
		logic [SCNT_W-1:0] settle_cnt;
		logic settled;
		logic [7:0] p0_s1;
		logic [7:0] p0_s2;
		logic [7:0] p0_s3;
		logic [7:0] p0_val;
	} acc_ctrl_t;

	acc_ctrl_t q;
	acc_ctrl_t n;
	logic sar_go;
	logic sar_done;
	logic [acc_pkg::RES_W-1:0] sar_result;
	logic bus_req;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic reg_hit(input logic [acc_pkg::ADDR_W-1:0] addr,
		input logic [9:0] idx);
		reg_hit = (addr == {idx, 2'b00});
	endfunction

	function automatic logic [acc_pkg::DATA_W-1:0] byte_word(input logic [7:0] b);
		byte_word = {24'h000000, b};
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		logic [7:0] wd;
		logic [acc_pkg::EVT_W-1:0] evt;
		logic [7:0] rd;
		logic wr;
		logic clearing_done;
		wd = avs_writedata[7:0];
		evt = '0;
		rd = 8'h00;
		wr = 1'b0;
		clearing_done = 1'b0;
		sar_go = 1'b0;
		n = q;

		// port 0 pins are asynchronous: three stages, a bit changes once two agree
		n.p0_s1 = port0_pin;
		n.p0_s2 = q.p0_s1;
		n.p0_s3 = q.p0_s2;
		n.p0_val = (q.p0_s3 & ~(q.p0_s2 ^ q.p0_s3)) | (q.p0_val & (q.p0_s2 ^ q.p0_s3));

		// settle timer is only a hint to software; starts are not gated by it
		if (!q.enable)
		begin
			n.settle_cnt = '0;
			n.settled = 1'b0;
		end
		else if (q.settle_cnt != SCNT_FULL)
		begin
			n.settle_cnt = q.settle_cnt + SCNT_W'(1);
		end
		else
		begin
			n.settled = 1'b1;
		end

		// one wait state: read data is captured here and stands while waitrequest is low
		n.ack = bus_req && !q.ack;
		if (avs_read && !q.ack)
		begin
			if (reg_hit(avs_address, acc_pkg::IDX_CTRL))
			begin
				rd[acc_pkg::CTL_ENABLE] = q.enable;
				rd[acc_pkg::CTL_RESULT_REGISTER_OUT] = q.result_register_out;
				rd[acc_pkg::CTL_DONE] = q.done;
				rd[acc_pkg::CTL_START] = q.start;
				rd[acc_pkg::CTL_CH_LO +: acc_pkg::CH_W] = q.channel;
			end
			else if (reg_hit(avs_address, acc_pkg::IDX_RESULT))
				rd = q.result;
			else if (reg_hit(avs_address, acc_pkg::IDX_GIE))
				rd[acc_pkg::GIE_BIT] = q.gie;
			else if (reg_hit(avs_address, acc_pkg::IDX_IEN1))
				rd[acc_pkg::IEN1_CONV_IE] = q.conv_ie;
			else if (reg_hit(avs_address, acc_pkg::IDX_P0_DIS))
				rd = q.p0_dis;
			else if (reg_hit(avs_address, acc_pkg::IDX_P0_PINS))
				rd = q.p0_val & ~q.p0_dis;
			else if (reg_hit(avs_address, acc_pkg::IDX_IRQ_STAT))
				rd[acc_pkg::EVT_W-1:0] = q.evt_stat;
			else if (reg_hit(avs_address, acc_pkg::IDX_IRQ_ENA))
				rd[acc_pkg::EVT_W-1:0] = q.evt_ena;
			else if (reg_hit(avs_address, acc_pkg::IDX_CONV_STAT))
			begin
				rd[acc_pkg::CST_SETTLED] = q.settled;
				rd[acc_pkg::CST_BUSY] = q.start;
			end
			n.rdata = byte_word(rd);
		end

		// writes act on the edge where waitrequest is sampled low
		wr = avs_write && q.ack && avs_byteenable[0];
		if (wr && reg_hit(avs_address, acc_pkg::IDX_CTRL))
		begin
			clearing_done = q.done && !wd[acc_pkg::CTL_DONE];
			n.result_register_out = wd[acc_pkg::CTL_RESULT_REGISTER_OUT];
			// channel is frozen while busy and by a write that clears done
			if (!q.start && !clearing_done)
				n.channel = wd[acc_pkg::CTL_CH_LO +: acc_pkg::CH_W];
			if (wd[acc_pkg::CTL_ENABLE])
				n.enable = 1'b1;
			else if (q.start || q.done)
				evt[acc_pkg::EVT_ENA_REFUSED] = q.enable;
			else
				n.enable = 1'b0;
			// hardware cannot be told to set done; writing one keeps it
			if (!wd[acc_pkg::CTL_DONE])
				n.done = 1'b0;
			if (wd[acc_pkg::CTL_START])
			begin
				if (q.enable && !q.start && !q.done)
				begin
					n.start = 1'b1;
					sar_go = 1'b1;
				end
				else
				begin
					evt[acc_pkg::EVT_START_REFUSED] = 1'b1;
				end
			end
		end
		if (wr && reg_hit(avs_address, acc_pkg::IDX_GIE))
			n.gie = wd[acc_pkg::GIE_BIT];
		if (wr && reg_hit(avs_address, acc_pkg::IDX_IEN1))
			n.conv_ie = wd[acc_pkg::IEN1_CONV_IE];
		if (wr && reg_hit(avs_address, acc_pkg::IDX_P0_DIS))
			n.p0_dis = wd;
		if (wr && reg_hit(avs_address, acc_pkg::IDX_IRQ_ENA))
			n.evt_ena = wd[acc_pkg::EVT_W-1:0];
		if (wr && reg_hit(avs_address, acc_pkg::IDX_IRQ_CLR))
			n.evt_stat = q.evt_stat & ~wd[acc_pkg::EVT_W-1:0];

		// completion comes after the write so a same-cycle clear of done loses
		if (sar_done && q.start)
		begin
			n.start = 1'b0;
			n.done = 1'b1;
			n.result = sar_result;
			evt[acc_pkg::EVT_DONE] = 1'b1;
		end

		// sticky events: set wins over a clear in the same cycle
		n.evt_stat = n.evt_stat | evt;
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q <= '0;
			q.enable <= acc_pkg::CTRL_RST[acc_pkg::CTL_ENABLE];
			q.result <= acc_pkg::RESULT_RST;
			q.p0_dis <= acc_pkg::P0_DIS_RST;
		end
		else if (ce)
		begin
			q <= n;
		end
	end

	// ************************************************************
	// converter core
	// ************************************************************
	acc_sar_engine
	#(
		.BIT_CYC(BIT_CYC)
	)
	u_sar
	(
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.start(sar_go),
		.cmp_pin(cmp_pin),
		.trial(sar_trial),
		.result(sar_result),
		.done(sar_done)
	);

	// ************************************************************
	// outputs
	// ************************************************************
	assign bus_req = avs_read || avs_write;
	assign avs_waitrequest = bus_req && !q.ack;
	assign avs_readdata = q.rdata;

	// the result register only changes on completion, so the dac level is steady
	assign result_register_level = q.result;
	assign result_register_drive = q.result_register_out && !q.enable;

	// two sources: done through conv_ie and the enabled sticky events, both gated by gie
	assign irq = (q.gie && q.conv_ie && q.done)
		|| (q.gie && |(q.evt_stat & q.evt_ena));

	assign mux_channel = q.channel;
	assign port0_input_off = q.p0_dis;

endmodule

// ---- acc_conv_ctrl_checker.sv ----
// checker for acc_conv_ctrl: bus answer timing, channel lock, input gating, dac drive
// assumes ce high while checked and a synchronous active-high reset
`timescale 1ns/100ps
module acc_conv_ctrl_checker
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire logic [1:0] mux_channel,
	input wire logic [7:0] sar_trial,
	input wire logic cmp_pin,
	input wire logic result_register_drive,
	input wire logic [7:0] result_register_level,
	input wire logic [7:0] port0_pin,
	input wire logic [7:0] port0_input_off
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	// a frozen clock enable stalls the bus answer, so nothing is judged then
	default disable iff (rst || !ce);
	logic wr_ok;
	logic wrc;
	logic wrd;
	logic rdv;
	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign wrc = wr_ok && avs_address == 12'h300;
	assign wrd = wr_ok && avs_address == 12'h3D8;
	assign rdv = avs_read && !avs_waitrequest;
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not one cycle late");
	AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("new request answered at once");
	AST_RD_UPPER: assert property (rdv |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	AST_MISALIGN: assert property (rdv && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
		else $error("misaligned read not zero");
	AST_CH_LOCK: assert property (!$past(rst) && $changed(mux_channel) |-> $past(wrc))
		else $error("channel moved without a control write");
	AST_DIS_WRITE: assert property (wrd |=> port0_input_off == $past(avs_writedata[7:0]))
		else $error("input disable not taken from write");
	AST_DIS_HOLD: assert property (!$past(rst) && $changed(port0_input_off) |-> $past(wrd))
		else $error("input disable moved without a write");
	AST_PIN_ZERO: assert property (rdv && avs_address == 12'h200 |->
		(avs_readdata[7:0] & port0_input_off) == 8'h00)
		else $error("disabled pin read as one");
	AST_DAC_RISE: assert property ($rose(result_register_drive) |-> $past(wrc))
		else $error("dac drive rose without a control write");
	AST_DAC_IDLE: assert property (result_register_drive |-> $stable(sar_trial))
		else $error("sar active while dac drives pin");
	COV_IRQ: cover property ($rose(irq));
	COV_DAC: cover property ($rose(result_register_drive));
	COV_PIN: cover property (rdv && avs_address == 12'h200);
endmodule

bind acc_conv_ctrl acc_conv_ctrl_checker i_acc_conv_ctrl_checker (.clk(clk), .rst(rst), .ce(ce),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
	.mux_channel(mux_channel), .sar_trial(sar_trial), .cmp_pin(cmp_pin),
	.result_register_drive(result_register_drive), .result_register_level(result_register_level), .port0_pin(port0_pin),
	.port0_input_off(port0_input_off));

// ---- acc_analog_model.sv ----
// analog side model: four fixed input levels behind the mux and an ideal comparator
// assumes the trial code is held steady while each bit is decided
`timescale 1ns/100ps
module acc_analog_model
#(
	parameter logic [31:0] CODES = 32'hFF803C01
)
(
	input wire logic [1:0] mux_channel,
	input wire logic [7:0] sar_trial,
	output logic cmp_pin
);
	// ************************************************************
	// comparator
	// ************************************************************
	// levels are given as their ideal rounded codes, so a correct search lands on them exactly
	assign cmp_pin = CODES[mux_channel*8 +: 8] >= sar_trial;
endmodule

// ---- tb_acc_conv_ctrl.sv ----
// self-checking bench for acc_conv_ctrl with the analog model on the mux side
// assumes acc_pkg is compiled first; ce and byte enables are held on
`timescale 1ns/100ps
module tb_acc_conv_ctrl;
	localparam logic [31:0] CODES = 32'hFF803C01;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [7:0] port0_pin = 8'hFF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, irq, cmp_pin, result_register_drive;
	logic [1:0] mux_channel;
	logic [7:0] sar_trial, result_register_level, port0_input_off;
	int fails = 0;
	int checks_done = 0;
	// ************************************************************
	// instances, clock and tasks
	// ************************************************************
	acc_conv_ctrl #(.SETTLE_CYC(4), .BIT_CYC(4)) i_acc_conv_ctrl (.clk(clk), .rst(rst),
		.ce(1'b1), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .mux_channel(mux_channel),
		.sar_trial(sar_trial), .cmp_pin(cmp_pin), .result_register_drive(result_register_drive),
		.result_register_level(result_register_level), .port0_pin(port0_pin), .port0_input_off(port0_input_off));
	acc_analog_model #(.CODES(CODES)) i_acc_analog_model (.mux_channel(mux_channel),
		.sar_trial(sar_trial), .cmp_pin(cmp_pin));
	always #25 clk = ~clk;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until waitrequest is sampled low; read data taken at that edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		// look at waitrequest mid-cycle, where it is settled, then act on the next rising edge
		@(negedge clk);
		while (avs_waitrequest !== 1'b0 && n < 20)
		begin
			n++;
			@(negedge clk);
		end
		chk("bus answer", 8'h00, {7'h0, avs_waitrequest});
		@(posedge clk);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, e, q);
	endtask
	task automatic wait_done;
		logic [7:0] q;
		int n;
		q = 8'h00;
		for (n = 0; n < 100 && q[4] !== 1'b1; n++)
			bus(1'b0, 12'h300, 8'h00, q);
		chk("done seen", 8'h01, {7'h0, q[4]});
	endtask
	task automatic t_regs;
		rc("disable reset", 12'h3D8, 8'h00);
		wr(12'h3D8, 8'h38);
		chk("input off", 8'h38, port0_input_off);
		rc("port0 read", 12'h200, 8'hC7);
		port0_pin <= 8'h0F;
		repeat (6) @(posedge clk);
		rc("port0 change", 12'h200, 8'h07);
		rc("unmapped", 12'h010, 8'h00);
		rc("misaligned", 12'h3D9, 8'h00);
	endtask
	task automatic t_conv;
		wr(12'h2A0, 8'h80);
		wr(12'h3A0, 8'h10);
		wr(12'h300, 8'h80);
		repeat (10) @(posedge clk);
		wr(12'h300, 8'h8A);
		rc("busy", 12'h300, 8'h8A);
		wr(12'h300, 8'h89);
		chk("channel lock", 8'h02, {6'h0, mux_channel});
		wr(12'h300, 8'h8B);
		wait_done;
		rc("finish", 12'h300, 8'h92);
		rc("refused start", 12'h400, 8'h03);
		rc("result", 12'h314, CODES[23:16]);
		chk("irq on", 8'h01, {7'h0, irq});
		wr(12'h2A0, 8'h00);
		chk("irq masked", 8'h00, {7'h0, irq});
		wr(12'h300, 8'h12);
		rc("enable kept", 12'h300, 8'h92);
		rc("enable refused", 12'h400, 8'h07);
		wr(12'h300, 8'h81);
		rc("clear keeps channel", 12'h300, 8'h82);
		rc("result hold", 12'h314, CODES[23:16]);
	endtask
	task automatic t_sweep;
		int ch;
		for (ch = 0; ch < 4; ch++)
		begin
			wr(12'h300, 8'h88 | 8'(ch));
			chk("start channel", 8'(ch), {6'h0, mux_channel});
			wait_done;
			rc("sweep result", 12'h314, CODES[ch*8 +: 8]);
			chk("result out", CODES[ch*8 +: 8], result_register_level);
			wr(12'h300, 8'h80 | 8'(ch));
		end
	endtask
	task automatic t_dac;
		wr(12'h300, 8'h00);
		wr(12'h300, 8'h20);
		chk("dac drives", 8'h01, {7'h0, result_register_drive});
		wr(12'h300, 8'hA0);
		chk("dac off", 8'h00, {7'h0, result_register_drive});
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_conv;
		t_sweep;
		t_dac;
		final_report;
	end
	// about 350 cycles are expected; a hang ends well past that
	initial
	begin
		repeat (8000) @(posedge clk);
		fails++;
		final_report;
	end
endmodule
